// *** sbc_pkg.sv ***
// Shared constants and types for the serial register access block
package sbc_pkg;

  // ****************************************************************
  // Frame layout
  // ****************************************************************
  localparam int         ADDR_W       = 7;
  localparam int         DATA_W       = 8;
  localparam int         FRAME_BITS   = 16;
  localparam int         CNT_W        = 8;
  localparam int         TYPE_POS     = 7;
  localparam int         DATA_LSB     = 8;
  localparam logic [7:0] FRAME_CLOCKS = 8'h10;
  localparam logic [7:0] ADDR_DONE    = 8'h06;
  localparam logic [7:0] DATA_FIRST   = 8'h08;

  // ****************************************************************
  // Address map
  // ****************************************************************
  localparam logic [6:0] CTRL_LAST        = 7'h1e;
  localparam logic [6:0] STAT_FIRST       = 7'h40;
  localparam logic [6:0] STAT_LAST        = 7'h7e;
  localparam int         CTRL_N           = 31;
  localparam int         STAT_N           = 63;
  localparam logic [6:0] MODE_SELECT_ADDR = 7'h01;
  localparam logic [6:0] HARDWARE_ADDR    = 7'h02;
  localparam logic [6:0] WATCHDOG_ADDR    = 7'h03;
  localparam logic [6:0] BUS_CTRL_ADDR    = 7'h04;
  localparam logic [6:0] HS_CTRL_ADDR     = 7'h14;
  localparam logic [6:0] BUS_STAT_ADDR    = 7'h44;
  localparam logic [6:0] WAKE_STAT_ADDR   = 7'h46;
  localparam logic [6:0] WAKE_LEVEL_ADDR  = 7'h48;
  localparam logic [6:0] HS_OC_STAT_ADDR  = 7'h54;
  localparam logic [6:0] HS_OL_STAT_ADDR  = 7'h55;
  localparam logic [6:0] FAMILY_ID_ADDR   = 7'h7e;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int         MODE_LSB   = 6;
  localparam int         SECOND_SUPPLY_OUTPUT_POS   = 5;
  localparam int         THIRD_SUPPLY_OUTPUT_POS   = 4;
  localparam int         CAN_LSB    = 0;
  localparam int         LIN_LSB    = 2;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] STAT_RESET = 8'h00;

  // ****************************************************************
  // Enumerations
  // ****************************************************************
  typedef enum logic [1:0] {
    SBC_MODE_NORMAL  = 2'b00,
    SBC_MODE_SLEEP   = 2'b01,
    SBC_MODE_STOP    = 2'b10,
    SBC_MODE_RESTART = 2'b11
  } sbc_mode_t;

  typedef enum logic [1:0] {
    SBC_TRX_OFF    = 2'b00,
    SBC_TRX_WAKE   = 2'b01,
    SBC_TRX_RXONLY = 2'b10,
    SBC_TRX_ACTIVE = 2'b11
  } sbc_trx_t;

endpackage

// *** sbc_sync.sv ***
// Two-stage synchroniser for levels entering the system clock domain
module sbc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         resetn,
  // Levels
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  // The first stage feeds only the second stage
  always_comb begin
    meta_d = din;
    sync_d = meta_q;
  end

  // Stage registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign dout = sync_q;

endmodule

// *** sbc_spi_link.sv ***
// Serial clock domain: bit counting, frame shifting and answer output
module sbc_spi_link #(
  parameter int CNT_W = sbc_pkg::CNT_W
) (
  // Link clock and reset
  input  wire logic             spiClk,
  input  wire logic             resetn,
  // Serial data in
  input  wire logic             spiSdi,
  // Quasi-static values from the system domain
  input  wire logic [CNT_W-1:0] startCnt,
  input  wire logic [7:0]       readData,
  // Frame state toward the system domain
  output logic      [CNT_W-1:0] edgeCnt,
  output logic      [15:0]      frameWord,
  output logic      [6:0]       addrHold,
  output logic                  reqToggle,
  // Serial data out
  output logic                  sdoBit
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [CNT_W-1:0] pos;
  logic [15:0]      shift_q;
  logic [15:0]      shift_d;
  logic [6:0]       addr_q;
  logic [6:0]       addr_d;
  logic             req_q;
  logic             req_d;
  logic             sdo_q;
  logic             sdo_d;

  // ****************************************************************
  // Rising edge: count, shift, hand the address over
  // ****************************************************************
  // The counter runs free; the system side subtracts the value it saw
  // at the frame start, so no edge outside a frame is ever needed
  always_comb begin
    pos     = cnt_q - startCnt;
    cnt_d   = cnt_q + 1'b1;
    shift_d = {spiSdi, shift_q[15:1]};
    addr_d  = addr_q;
    req_d   = req_q;
    if (pos == CNT_W'(sbc_pkg::ADDR_DONE)) begin
      addr_d = shift_d[15:9];
      req_d  = ~req_q;
    end
  end

  always_ff @(posedge spiClk or negedge resetn) begin
    if (!resetn) begin
      cnt_q   <= '0;
      shift_q <= '0;
      addr_q  <= '0;
      req_q   <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      shift_q <= shift_d;
      addr_q  <= addr_d;
      req_q   <= req_d;
    end
  end

  // ****************************************************************
  // Falling edge: answer bits
  // ****************************************************************
  // Low byte carries no status here; the data byte follows the address.
  // readData settles at least fifteen system cycles before it is first used.
  always_comb begin
    sdo_d = 1'b0;
    if (pos >= CNT_W'(sbc_pkg::DATA_FIRST) && pos < CNT_W'(sbc_pkg::FRAME_CLOCKS)) begin
      sdo_d = readData[pos[2:0]];
    end
  end

  always_ff @(negedge spiClk or negedge resetn) begin
    if (!resetn) begin
      sdo_q <= 1'b0;
    end else begin
      sdo_q <= sdo_d;
    end
  end

  assign edgeCnt   = cnt_q;
  assign frameWord = shift_q;
  assign addrHold  = addr_q;
  assign reqToggle = req_q;
  assign sdoBit    = sdo_q;

  a_addr_request : assert property (@(posedge spiClk) disable iff (!resetn)
    $changed(req_q) |-> (cnt_q - startCnt) == CNT_W'(8'h07))
    else $error("address request not after the seventh clock");

endmodule

// *** sbc_spi_register_map.sv ***
// Register bank behind the 16-bit serial port, with mode entry effects
module sbc_spi_register_map #(
  parameter int         HS_N         = 4,
  parameter int         WK_N         = 2,
  parameter logic [7:0] FAM_ID_VALUE = 8'h5a  // Arbitrary identity value
) (
  // Clock and reset
  input  wire logic            sys_clk,
  input  wire logic            resetn,
  // Serial pins
  input  wire logic            spiClk,
  input  wire logic            spiCsn,
  input  wire logic            spiSdi,
  output logic                 spiSdoOut,
  output logic                 spiSdoOe,
  // Device events, same clock
  input  wire logic            restartReq,
  input  wire logic            failTrigger,
  input  wire logic [HS_N-1:0] hsOverload,
  input  wire logic [HS_N-1:0] hsOpenLoad,
  input  wire logic [1:0]      busFail,
  // Wake pins
  input  wire logic [WK_N-1:0] wakePin,
  // Controlled outputs
  output logic      [1:0]      modeOut,
  output logic      [HS_N-1:0] hsEnable,
  output logic                 secondSupplyEn,
  output logic                 thirdSupplyEn,
  output logic      [1:0]      canMode,
  output logic      [1:0]      linMode,
  output logic                 failOut
);

  localparam int CW = sbc_pkg::CNT_W;

  // ****************************************************************
  // Address decoding and transceiver mode helpers
  // ****************************************************************
  function automatic logic isCtrl(input logic [6:0] a);
    return a <= sbc_pkg::CTRL_LAST;
  endfunction

  function automatic logic isStat(input logic [6:0] a);
    return a >= sbc_pkg::STAT_FIRST && a <= sbc_pkg::STAT_LAST;
  endfunction

  function automatic logic isClearable(input logic [6:0] a);
    return a != sbc_pkg::WAKE_LEVEL_ADDR && a != sbc_pkg::FAMILY_ID_ADDR;
  endfunction

  function automatic logic [1:0] trxSleep(input logic [1:0] t);
    if (t == sbc_pkg::SBC_TRX_OFF || t == sbc_pkg::SBC_TRX_WAKE) return t;
    return sbc_pkg::SBC_TRX_WAKE;
  endfunction

  function automatic logic [1:0] trxRestart(input logic [1:0] t);
    if (t == sbc_pkg::SBC_TRX_OFF || t == sbc_pkg::SBC_TRX_WAKE) return t;
    return sbc_pkg::SBC_TRX_ACTIVE;
  endfunction

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [7:0]            ctrl_q [sbc_pkg::CTRL_N];
  logic [7:0]            ctrl_d [sbc_pkg::CTRL_N];
  logic [7:0]            stat_q [sbc_pkg::STAT_N];
  logic [7:0]            stat_d [sbc_pkg::STAT_N];
  sbc_pkg::sbc_mode_t    mode_q;
  sbc_pkg::sbc_mode_t    mode_d;
  logic [CW-1:0]         startCnt_q;
  logic [CW-1:0]         startCnt_d;
  logic [7:0]            readData_q;
  logic [7:0]            readData_d;
  logic                  csnPrev_q;
  logic                  csnPrev_d;
  logic                  reqPrev_q;
  logic                  reqPrev_d;
  logic [WK_N:0]         wakePrev_q;
  logic [WK_N:0]         wakePrev_d;
  logic                  failOut_q;
  logic                  failOut_d;
  logic                  sdoOe_q;
  logic                  sdoOe_d;
  logic [CW-1:0]         edgeCnt;
  logic [15:0]           frameWord;
  logic [6:0]            addrHold;
  logic                  reqToggle;
  logic                  sdoBit;
  logic [WK_N+2:0]       syncOut;
  logic                  csnS;
  logic                  reqS;
  logic [WK_N-1:0]       wakeS;
  logic [CW-1:0]         clkCount;
  logic                  csnRise;
  logic                  frameOk;
  logic [6:0]            fAddr;
  logic                  fType;
  logic [7:0]            fData;
  logic [7:0]            wrByte;
  logic                  lowPower;

  // ****************************************************************
  // Link side and crossings
  // ****************************************************************
  sbc_spi_link #(.CNT_W(CW)) uLink (
    .spiClk    (spiClk),
    .resetn    (resetn),
    .spiSdi    (spiSdi),
    .startCnt  (startCnt_q),
    .readData  (readData_q),
    .edgeCnt   (edgeCnt),
    .frameWord (frameWord),
    .addrHold  (addrHold),
    .reqToggle (reqToggle),
    .sdoBit    (sdoBit)
  );

  // Select enters inverted so its reset value is the idle level; top bit marks valid data
  sbc_sync #(.W(WK_N + 3)) uSync (
    .clk    (sys_clk),
    .resetn (resetn),
    .din    ({1'b1, wakePin, reqToggle, ~spiCsn}),
    .dout   (syncOut)
  );

  // Counter and frame word are still between frames, so read directly
  always_comb begin
    csnS     = !syncOut[0];
    reqS     = syncOut[1];
    wakeS    = syncOut[WK_N+1:2];
    clkCount = edgeCnt - startCnt_q;
    csnRise  = csnS && !csnPrev_q;
    frameOk  = csnRise && clkCount == CW'(sbc_pkg::FRAME_CLOCKS)
               && mode_q != sbc_pkg::SBC_MODE_RESTART;
    fAddr    = frameWord[sbc_pkg::ADDR_W-1:0];
    fType    = frameWord[sbc_pkg::TYPE_POS];
    fData    = frameWord[sbc_pkg::DATA_LSB +: sbc_pkg::DATA_W];
    lowPower = mode_q == sbc_pkg::SBC_MODE_SLEEP || mode_q == sbc_pkg::SBC_MODE_STOP;
  end

  // ****************************************************************
  // Answer byte lookup
  // ****************************************************************
  // Taken mid-frame from the stored state, so a write in this frame
  // cannot show until a later one
  function automatic logic [7:0] readByte(input logic [6:0] a);
    logic [7:0] r;
    r = 8'h00;
    if (isCtrl(a)) r = ctrl_q[a[4:0]];
    else if (a == sbc_pkg::WAKE_LEVEL_ADDR) r[WK_N-1:0] = wakeS;
    else if (a == sbc_pkg::FAMILY_ID_ADDR) r = FAM_ID_VALUE;
    else if (isStat(a)) r = stat_q[a[5:0]];
    return r;
  endfunction

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    ctrl_d     = ctrl_q;
    stat_d     = stat_q;
    mode_d     = mode_q;
    csnPrev_d  = csnS;
    reqPrev_d  = reqS;
    wakePrev_d = {syncOut[WK_N+2], wakeS};
    sdoOe_d    = !csnS;
    startCnt_d = (!csnS && csnPrev_q) ? edgeCnt : startCnt_q;
    readData_d = (reqS != reqPrev_q) ? readByte(addrHold) : readData_q;
    wrByte     = fData;
    // Frame command, only on a whole frame with the type bit set
    if (frameOk && fType) begin
      if (isCtrl(fAddr)) begin
        if (fAddr == sbc_pkg::MODE_SELECT_ADDR) begin
          if (mode_q != sbc_pkg::SBC_MODE_NORMAL) begin
            wrByte[sbc_pkg::SECOND_SUPPLY_OUTPUT_POS] = ctrl_q[fAddr[4:0]][sbc_pkg::SECOND_SUPPLY_OUTPUT_POS];
            wrByte[sbc_pkg::THIRD_SUPPLY_OUTPUT_POS] = ctrl_q[fAddr[4:0]][sbc_pkg::THIRD_SUPPLY_OUTPUT_POS];
          end
          // Restart is entered by the device only, never by command
          if (fData[sbc_pkg::MODE_LSB +: 2] != sbc_pkg::SBC_MODE_RESTART) begin
            mode_d = sbc_pkg::sbc_mode_t'(fData[sbc_pkg::MODE_LSB +: 2]);
          end
          ctrl_d[fAddr[4:0]] = wrByte;
        end else if (fAddr != sbc_pkg::HS_CTRL_ADDR || mode_q == sbc_pkg::SBC_MODE_NORMAL) begin
          ctrl_d[fAddr[4:0]] = wrByte;
        end
      end else if (isStat(fAddr) && isClearable(fAddr)) begin
        stat_d[fAddr[5:0]] = sbc_pkg::STAT_RESET;
      end
    end
    // Restart request from the device overrides any command
    unique case (mode_q)
      sbc_pkg::SBC_MODE_NORMAL,
      sbc_pkg::SBC_MODE_SLEEP,
      sbc_pkg::SBC_MODE_STOP: begin
        if (restartReq) mode_d = sbc_pkg::SBC_MODE_RESTART;
      end
      sbc_pkg::SBC_MODE_RESTART: begin
        mode_d = restartReq ? sbc_pkg::SBC_MODE_RESTART : sbc_pkg::SBC_MODE_NORMAL;
      end
    endcase
    // Entry effects; diagnosis bytes are never touched here
    if (mode_d != mode_q) begin
      unique case (mode_d)
        // Transceiver bits pass through untouched on these entries
        sbc_pkg::SBC_MODE_NORMAL, sbc_pkg::SBC_MODE_STOP: ;
        sbc_pkg::SBC_MODE_SLEEP: begin
          ctrl_d[sbc_pkg::BUS_CTRL_ADDR[4:0]][sbc_pkg::CAN_LSB +: 2] =
            trxSleep(ctrl_q[sbc_pkg::BUS_CTRL_ADDR[4:0]][sbc_pkg::CAN_LSB +: 2]);
          ctrl_d[sbc_pkg::BUS_CTRL_ADDR[4:0]][sbc_pkg::LIN_LSB +: 2] =
            trxSleep(ctrl_q[sbc_pkg::BUS_CTRL_ADDR[4:0]][sbc_pkg::LIN_LSB +: 2]);
        end
        sbc_pkg::SBC_MODE_RESTART: begin
          ctrl_d[sbc_pkg::HS_CTRL_ADDR[4:0]] = sbc_pkg::CTRL_RESET;
          ctrl_d[sbc_pkg::MODE_SELECT_ADDR[4:0]][sbc_pkg::SECOND_SUPPLY_OUTPUT_POS] = 1'b0;
          ctrl_d[sbc_pkg::BUS_CTRL_ADDR[4:0]][sbc_pkg::CAN_LSB +: 2] =
            trxRestart(ctrl_q[sbc_pkg::BUS_CTRL_ADDR[4:0]][sbc_pkg::CAN_LSB +: 2]);
          ctrl_d[sbc_pkg::BUS_CTRL_ADDR[4:0]][sbc_pkg::LIN_LSB +: 2] =
            trxRestart(ctrl_q[sbc_pkg::BUS_CTRL_ADDR[4:0]][sbc_pkg::LIN_LSB +: 2]);
        end
      endcase
    end
    // Failures switch the output off in any mode, with no mode change
    ctrl_d[sbc_pkg::HS_CTRL_ADDR[4:0]][HS_N-1:0] =
      ctrl_d[sbc_pkg::HS_CTRL_ADDR[4:0]][HS_N-1:0] & ~hsOverload;
    // Events set after the clear so a coinciding event is kept
    stat_d[sbc_pkg::HS_OC_STAT_ADDR[5:0]][HS_N-1:0] =
      stat_d[sbc_pkg::HS_OC_STAT_ADDR[5:0]][HS_N-1:0] | hsOverload;
    stat_d[sbc_pkg::HS_OL_STAT_ADDR[5:0]][HS_N-1:0] =
      stat_d[sbc_pkg::HS_OL_STAT_ADDR[5:0]][HS_N-1:0] | hsOpenLoad;
    stat_d[sbc_pkg::BUS_STAT_ADDR[5:0]][1:0] =
      stat_d[sbc_pkg::BUS_STAT_ADDR[5:0]][1:0] | busFail;
    stat_d[sbc_pkg::WAKE_STAT_ADDR[5:0]][WK_N-1:0] =
      stat_d[sbc_pkg::WAKE_STAT_ADDR[5:0]][WK_N-1:0] | (wakeS & ~wakePrev_q[WK_N-1:0] &
      {WK_N{wakePrev_q[WK_N]}});  // Edges only once the stages hold pin data
    // Mode bits always show the mode in force
    ctrl_d[sbc_pkg::MODE_SELECT_ADDR[4:0]][sbc_pkg::MODE_LSB +: 2] = mode_d;
    // Fail output only ever sets; modes never release it
    failOut_d = failOut_q || failTrigger;
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < sbc_pkg::CTRL_N; i++) ctrl_q[i] <= sbc_pkg::CTRL_RESET;
      for (int j = 0; j < sbc_pkg::STAT_N; j++) stat_q[j] <= sbc_pkg::STAT_RESET;
      mode_q     <= sbc_pkg::SBC_MODE_NORMAL;
      startCnt_q <= '0;
      readData_q <= 8'h00;
      csnPrev_q  <= 1'b1;
      reqPrev_q  <= 1'b0;
      wakePrev_q <= '0;
      failOut_q  <= 1'b0;
      sdoOe_q    <= 1'b0;
    end else begin
      ctrl_q     <= ctrl_d;
      stat_q     <= stat_d;
      mode_q     <= mode_d;
      startCnt_q <= startCnt_d;
      readData_q <= readData_d;
      csnPrev_q  <= csnPrev_d;
      reqPrev_q  <= reqPrev_d;
      wakePrev_q <= wakePrev_d;
      failOut_q  <= failOut_d;
      sdoOe_q    <= sdoOe_d;
    end
  end

  // Outputs straight from flip-flops
  assign modeOut        = mode_q;
  assign hsEnable       = ctrl_q[sbc_pkg::HS_CTRL_ADDR[4:0]][HS_N-1:0];
  assign secondSupplyEn = ctrl_q[sbc_pkg::MODE_SELECT_ADDR[4:0]][sbc_pkg::SECOND_SUPPLY_OUTPUT_POS];
  assign thirdSupplyEn  = ctrl_q[sbc_pkg::MODE_SELECT_ADDR[4:0]][sbc_pkg::THIRD_SUPPLY_OUTPUT_POS];
  assign canMode        = ctrl_q[sbc_pkg::BUS_CTRL_ADDR[4:0]][sbc_pkg::CAN_LSB +: 2];
  assign linMode        = ctrl_q[sbc_pkg::BUS_CTRL_ADDR[4:0]][sbc_pkg::LIN_LSB +: 2];
  assign failOut        = failOut_q;
  assign spiSdoOut      = sdoBit;
  assign spiSdoOe       = sdoOe_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_mode_bits_mirror : assert property (@(posedge sys_clk) disable iff (!resetn)
    ctrl_q[sbc_pkg::MODE_SELECT_ADDR[4:0]][sbc_pkg::MODE_LSB +: 2] == mode_q)
    else $error("mode bits differ from the mode in force");

  a_sleep_trx_fix : assert property (@(posedge sys_clk) disable iff (!resetn)
    ($changed(mode_q) && mode_q == sbc_pkg::SBC_MODE_SLEEP) |->
      canMode inside {sbc_pkg::SBC_TRX_OFF, sbc_pkg::SBC_TRX_WAKE}
      && linMode inside {sbc_pkg::SBC_TRX_OFF, sbc_pkg::SBC_TRX_WAKE})
    else $error("transceiver left active on entry to sleep");

  a_stop_trx_keep : assert property (@(posedge sys_clk) disable iff (!resetn)
    ($changed(mode_q) && mode_q == sbc_pkg::SBC_MODE_STOP) |->
      canMode == $past(canMode) && linMode == $past(linMode))
    else $error("transceiver bits changed on entry to stop");

  a_restart_clear : assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(mode_q == sbc_pkg::SBC_MODE_RESTART) |-> hsEnable == '0 && !secondSupplyEn)
    else $error("switch or supply setup kept into restart");

  a_fail_sticky : assert property (@(posedge sys_clk) disable iff (!resetn)
    failOut_q |=> failOut_q [*8])
    else $error("fail output released");

  a_lowpower_cfg : assert property (@(posedge sys_clk) disable iff (!resetn)
    (lowPower && $past(lowPower)) |-> (hsEnable & ~$past(hsEnable)) == '0)
    else $error("switch enabled outside normal mode");

  a_hs_fail_off : assert property (@(posedge sys_clk) disable iff (!resetn)
    (|hsOverload && !restartReq && mode_q != sbc_pkg::SBC_MODE_RESTART) |=>
      (hsEnable & $past(hsOverload)) == '0 && mode_q == $past(mode_q)
      || $past(frameOk))
    else $error("failed switch still on or mode changed");

  a_wake_level_live : assert property (@(posedge sys_clk) disable iff (!resetn)
    (reqS != reqPrev_q && addrHold == sbc_pkg::WAKE_LEVEL_ADDR) |=>
      readData_q[WK_N-1:0] == $past(wakeS))
    else $error("wake level answer is not the pin level");

  a_discard_bad : assert property (@(posedge sys_clk) disable iff (!resetn)
    (csnRise && clkCount != CW'(sbc_pkg::FRAME_CLOCKS)) |=>
      ctrl_q[sbc_pkg::WATCHDOG_ADDR[4:0]] == $past(ctrl_q[sbc_pkg::WATCHDOG_ADDR[4:0]]))
    else $error("short or long frame was executed");

endmodule

// *** sbc_master_model.sv ***
// Serial master model that sends framed transfers to the register block
module sbc_master_model (
  // Serial lines toward the device
  output logic      spiClk,
  output logic      spiCsn,
  output logic      spiSdi,
  // Answer line
  input  wire logic sdoLine
);
  timeunit 1ns;
  timeprecision 100ps;
  // Clock stands low and select is released outside frames
  initial begin
    spiClk = 1'b0;
    spiCsn = 1'b1;
    spiSdi = 1'b0;
  end
  // One frame, bit 0 first, 48 ns clock, answer taken on rising edges
  task automatic xfer(input logic [15:0] w, input int nClk, output logic [7:0] ans);
    logic [15:0] got;
    got = '0;
    spiCsn = 1'b0;
    #20;
    for (int i = 0; i < nClk; i++) begin
      spiSdi = w[i % 16];
      #24 spiClk = 1'b1;
      got[i % 16] = sdoLine;
      #24 spiClk = 1'b0;
    end
    spiSdi = ~spiSdi; // Released data shows a changed level
    #10 spiCsn = 1'b1;
    #60;
    ans = got[15:8];
  endtask
endmodule

// *** sbc_spi_register_map_bench.sv ***
// Self-checking bench for the serial register block
`define CHK(n, e, g) begin checksDone++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module sbc_spi_register_map_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic       sys_clk = 1'b0, resetn = 1'b0, restartReq = 1'b0, failTrigger = 1'b0;
  logic [3:0] hsOverload = '0, hsOpenLoad = '0, hsEnable;
  logic [1:0] busFail = '0, wakePin = 2'b10, modeOut, canMode, linMode;
  logic       spiClk, spiCsn, spiSdi, spiSdoOut, spiSdoOe, secondSupplyEn, thirdSupplyEn, failOut;
  logic [7:0] ans;
  int         mismatches = 0, checksDone = 0;
  wire        sdoLine = spiSdoOe ? spiSdoOut : 1'b1; // Pull-up while released
  always #2 sys_clk = ~sys_clk;
  sbc_master_model mst (.spiClk(spiClk), .spiCsn(spiCsn), .spiSdi(spiSdi), .sdoLine(sdoLine));
  sbc_spi_register_map uut (.sys_clk(sys_clk), .resetn(resetn), .spiClk(spiClk),
    .spiCsn(spiCsn), .spiSdi(spiSdi), .spiSdoOut(spiSdoOut), .spiSdoOe(spiSdoOe),
    .restartReq(restartReq), .failTrigger(failTrigger), .hsOverload(hsOverload),
    .hsOpenLoad(hsOpenLoad), .busFail(busFail), .wakePin(wakePin), .modeOut(modeOut),
    .hsEnable(hsEnable), .secondSupplyEn(secondSupplyEn), .thirdSupplyEn(thirdSupplyEn),
    .canMode(canMode), .linMode(linMode), .failOut(failOut));
  // Frame helpers: write with type bit one, read with chosen type bit
  task automatic wr(input logic [6:0] a, input logic [7:0] d, input int n = 16);
    mst.xfer({d, 1'b1, a}, n, ans);
  endtask
  task automatic rd(input logic [6:0] a, input logic t = 1'b0);
    mst.xfer({8'h00, t, a}, 16, ans);
  endtask
  // Drive an event input for one system cycle
  task automatic overload(input logic [3:0] v);
    @(posedge sys_clk) #1 hsOverload = v;
    @(posedge sys_clk) #1 hsOverload = 4'h0;
  endtask
  task give_verdict;
    if (mismatches == 0 && checksDone > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge sys_clk);
    #1 resetn = 1'b1;
    repeat (4) @(posedge sys_clk);
    wr(sbc_pkg::WATCHDOG_ADDR, 8'ha5);
    `CHK("old", 8'h00, ans)
    mst.xfer({8'h3c, 1'b0, 7'h03}, 16, ans);
    `CHK("new", 8'ha5, ans)
    for (int n = 0; n <= 17; n += 17) begin
      wr(sbc_pkg::WATCHDOG_ADDR, 8'hff, n);
      rd(sbc_pkg::WATCHDOG_ADDR);
      `CHK("count", 8'ha5, ans)
    end
    wr(sbc_pkg::WATCHDOG_ADDR, 8'hff, 15);
    rd(sbc_pkg::WATCHDOG_ADDR);
    `CHK("short", 8'ha5, ans)
    rd(sbc_pkg::FAMILY_ID_ADDR, 1'b1);
    rd(sbc_pkg::FAMILY_ID_ADDR);
    `CHK("family", 8'h5a, ans)
    rd(sbc_pkg::WAKE_LEVEL_ADDR, 1'b1);
    rd(sbc_pkg::WAKE_LEVEL_ADDR);
    `CHK("level", 8'h02, ans)
    rd(sbc_pkg::WAKE_STAT_ADDR, 1'b1);
    `CHK("no wake", 8'h00, ans)
    @(posedge sys_clk) #1 wakePin = 2'b11;
    rd(sbc_pkg::WAKE_STAT_ADDR, 1'b1);
    `CHK("wake edge", 8'h01, ans)
    overload(4'h4);
    rd(sbc_pkg::HS_OC_STAT_ADDR, 1'b1);
    `CHK("oc old", 8'h04, ans)
    rd(sbc_pkg::HS_OC_STAT_ADDR);
    `CHK("oc clr", 8'h00, ans)
    wr(sbc_pkg::HS_CTRL_ADDR, 8'h03);
    wr(sbc_pkg::BUS_CTRL_ADDR, 8'h0e);
    @(posedge sys_clk) #1 failTrigger = 1'b1;
    @(posedge sys_clk) #1 failTrigger = 1'b0;
    wr(sbc_pkg::MODE_SELECT_ADDR, 8'hb0);
    `CHK("stop", 11'h567, {modeOut, canMode, linMode, hsEnable, failOut})
    wr(sbc_pkg::MODE_SELECT_ADDR, 8'h40);
    wr(sbc_pkg::HS_CTRL_ADDR, 8'h00);
    overload(4'h1);
    `CHK("sleep", 11'h2a5, {modeOut, canMode, linMode, hsEnable, secondSupplyEn})
    @(posedge sys_clk) #1 {hsOpenLoad, busFail} = 6'h22;
    @(posedge sys_clk) #1 {hsOpenLoad, busFail} = 6'h00;
    rd(sbc_pkg::HS_OL_STAT_ADDR, 1'b1);
    `CHK("open load", 8'h08, ans)
    rd(sbc_pkg::BUS_STAT_ADDR);
    `CHK("bus fail", 8'h02, ans)
    wr(sbc_pkg::BUS_CTRL_ADDR, 8'h06);
    @(posedge sys_clk) #1 restartReq = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1 `CHK("restart", 11'h7a0, {modeOut, canMode, linMode, hsEnable, secondSupplyEn})
    restartReq = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1 `CHK("normal", 4'h3, {modeOut, failOut, thirdSupplyEn})
    rd(sbc_pkg::MODE_SELECT_ADDR);
    `CHK("mode bits", 8'h10, ans)
    rd(sbc_pkg::HS_OC_STAT_ADDR);
    `CHK("flag kept", 8'h01, ans)
    wr(sbc_pkg::HS_CTRL_ADDR, 8'h01);
    `CHK("drive", 4'h1, hsEnable)
    give_verdict;
  end
  // Hang guard
  initial begin
    #300000;
    mismatches++;
    give_verdict;
  end
endmodule
